//--- adc_key_monitor.sv
// port assertions for the converter and key wakeup
`timescale 1ns/100ps
module adc_key_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic stop_entry,
	input wire logic [5:0] key_input_n,
	input wire logic sample_hold,
	input wire logic conv_done_irq,
	input wire logic key_wake_irq,
	input wire logic key_conv_trigger
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_hold4;
		sample_hold [*4] ##1 !sample_hold;
	endsequence
	property p_done_time; conv_done_irq |-> $past(sample_hold, 33); endproperty
	property p_done_pulse; conv_done_irq |=> !conv_done_irq; endproperty
	property p_hold_len; $rose(sample_hold) |-> s_hold4; endproperty
	property p_stop; stop_entry |=> !conv_done_irq && !sample_hold; endproperty
	property p_trig_pulse; key_conv_trigger |=> !key_conv_trigger; endproperty
	property p_trig_wake; key_conv_trigger |-> key_wake_irq; endproperty
	property p_wake_low; $rose(key_wake_irq) |-> key_input_n != 6'h3F; endproperty
	property p_filter; $rose(key_wake_irq) |-> $past(key_input_n, 900) == key_input_n; endproperty
	a_done_time: assert property (p_done_time) else $error("done time");
	a_done_pulse: assert property (p_done_pulse) else $error("done pulse");
	a_hold_len: assert property (p_hold_len) else $error("hold length");
	a_stop: assert property (p_stop) else $error("stop activity");
	a_trig_pulse: assert property (p_trig_pulse) else $error("trigger pulse");
	a_trig_wake: assert property (p_trig_wake) else $error("trigger no key");
	a_wake_low: assert property (p_wake_low) else $error("wake no key");
	a_filter: assert property (p_filter) else $error("filter short");
endmodule
bind adc_key_top adc_key_monitor i_adc_key_monitor (.hclk, .hresetn, .stop_entry, .key_input_n,
	.sample_hold, .conv_done_irq, .key_wake_irq, .key_conv_trigger);

//--- adc_key_partner.sv
// far side: analog inputs with sample and hold, key pins
`timescale 1ns/100ps
module adc_key_partner (
	input wire logic hclk,
	input wire logic sample_hold,
	input wire logic [2:0] chan_sel,
	input wire logic [7:0] sar_trial,
	input wire logic [5:0][7:0] vin,
	input wire logic [5:0] key_lvl,
	output logic cmp_in,
	output logic [5:0] key_input_n
);
	logic [7:0] held = 8'h00;
	always @(posedge hclk) begin
		if (sample_hold) begin
			held <= vin[chan_sel];
		end
	end
	assign cmp_in = held >= sar_trial;
	assign key_input_n = key_lvl;
endmodule

//--- adc_key_pkg.sv
// shared constants and types for the converter sequencer and key wakeup
package adc_key_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_CTRL_A = 12'h000;
	localparam logic [11:0] OFS_CTRL_B = 12'h004;
	localparam logic [11:0] OFS_RESULT = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;
	localparam logic [11:0] OFS_KEY_WAKE = 12'hFD0;

	// field positions and key count
	localparam int START_BIT = 7;
	localparam int MODE_HI = 6;
	localparam int MODE_LO = 5;
	localparam int END_BIT = 5;
	localparam int BUSY_BIT = 4;
	localparam int TRIG_EN_BIT = 7;
	localparam int KEY_COUNT = 6;

	// mode field codes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SOFT = 2'h1;
	localparam logic [1:0] MODE_TRIG = 2'h2;

	// reset values and wake enable write mask
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [7:0] WAKE_EN_RST = 8'h00;
	localparam logic [7:0] WAKE_EN_MASK = 8'hBF;

	// timing
	localparam int CLK_NS = 25;
	localparam int FILT_NS = 24000;
	localparam logic [9:0] FILT_COUNT = 10'((FILT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] SAMPLE_CYCLES = 3'h4;
	localparam logic [2:0] STEP_CYCLES = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONV = 3'b100
	} conv_state_t;

	typedef struct packed {
		logic wr_pend;
		logic rd_pend;
		logic [11:0] addr;
	} bus_req_t;

	typedef struct packed {
		bus_req_t req;
		logic hreadyout;
		logic [31:0] hrdata;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] result;
		logic end_flag;
		logic busy;
		logic trig_done;
		conv_state_t state;
		logic [2:0] cnt;
		logic [2:0] bit_idx;
		logic [7:0] trial;
		logic done_irq;
		logic cmp_s1;
		logic cmp_s2;
		logic [7:0] wake_en;
		logic [5:0] key_s1;
		logic [5:0] key_s2;
		logic [5:0] key_filt;
		logic [5:0][9:0] filt_cnt;
		logic wake_irq;
		logic trig;
	} core_state_t;

endpackage

//--- adc_key_top.sv
// converter sequencer and key wakeup unit behind an ahb-lite slave
`timescale 1ns/100ps

// Contract
// - modes: disabled, software start, trigger start
// - done irq fires with end flag
// - stop halts conversion, no end flag
// - disabling aborts, result untouched
// - starts ignored while disabled
// - reset selects disabled mode
// - mode 01 selects software start
// - conversion end stores result, sets flag
// - result read clears end flag
// - restart clears flag, old result kept
// - trigger mode converts on key trigger
// - stop resets controls, discards result
// - result is 8-bit unsigned code
// - per-key wake enable bits 0..5
// - enabled low key raises wake irq
// - bit 7 gates converter trigger
// - filter rejects pulses under 24 us
// - monitor reads key levels bits 0..5
// - busy set on start, cleared on end
module adc_key_top
	import adc_key_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic stop_entry,
	input wire logic cmp_in,
	input wire logic [5:0] key_input_n,
	output logic [2:0] chan_sel,
	output logic [7:0] sar_trial,
	output logic sample_hold,
	output logic conv_done_irq,
	output logic key_wake_irq,
	output logic key_conv_trigger
);

	core_state_t state_reg;
	core_state_t state_next;

	localparam core_state_t STATE_RST = '{
		req: '{wr_pend: 1'b0, rd_pend: 1'b0, addr: 12'h000},
		hreadyout: 1'b1,
		hrdata: 32'h00000000,
		ctrl_a: CTRL_A_RST,
		ctrl_b: CTRL_B_RST,
		result: RESULT_RST,
		end_flag: 1'b0,
		busy: 1'b0,
		trig_done: 1'b0,
		state: ST_IDLE,
		cnt: 3'h0,
		bit_idx: 3'h0,
		trial: 8'h00,
		done_irq: 1'b0,
		cmp_s1: 1'b0,
		cmp_s2: 1'b0,
		wake_en: WAKE_EN_RST,
		key_s1: 6'h3F,
		key_s2: 6'h3F,
		key_filt: 6'h3F,
		filt_cnt: '0,
		wake_irq: 1'b0,
		trig: 1'b0
	};

	always_comb begin
		core_state_t n;
		logic [5:0] fell;
		logic start_req;
		logic [7:0] kept;
		logic [7:0] bit_mask;
		logic [1:0] new_mode;
		n = state_reg;
		fell = 6'h00;
		start_req = 1'b0;
		kept = 8'h00;
		bit_mask = 8'(8'h01 << state_reg.bit_idx);
		new_mode = hwdata[MODE_HI:MODE_LO];
		n.done_irq = 1'b0;
		n.trig = 1'b0;

		// pin synchronisers
		n.cmp_s1 = cmp_in;
		n.cmp_s2 = state_reg.cmp_s1;
		n.key_s1 = key_input_n;
		n.key_s2 = state_reg.key_s1;

		// noise filter: level must hold for the full window before it is taken
		for (int i = 0; i < KEY_COUNT; i++) begin
			if (state_reg.key_s2[i] == state_reg.key_filt[i]) begin
				n.filt_cnt[i] = 10'h000;
			end else if (state_reg.filt_cnt[i] == FILT_COUNT - 10'h001) begin
				n.filt_cnt[i] = 10'h000;
				n.key_filt[i] = state_reg.key_s2[i];
			end else begin
				n.filt_cnt[i] = state_reg.filt_cnt[i] + 10'h001;
			end
			fell[i] = state_reg.key_filt[i] & ~n.key_filt[i];
		end
		// same edge as the trigger, so a trigger never precedes its wake request
		n.wake_irq = |(state_reg.wake_en[5:0] & ~n.key_filt);
		n.trig = state_reg.wake_en[TRIG_EN_BIT] & |(fell & state_reg.wake_en[5:0]);

		// ahb-lite address phase
		n.hreadyout = 1'b1;
		n.req.wr_pend = 1'b0;
		n.req.rd_pend = 1'b0;
		if (hsel && htrans[1] && hready) begin
			n.req.addr = haddr[11:0];
			n.req.wr_pend = hwrite;
			n.req.rd_pend = ~hwrite;
			n.hreadyout = hwrite;
		end

		// read data phase: one wait state, then data from a flop
		if (state_reg.req.rd_pend) begin
			n.hreadyout = 1'b1;
			case (state_reg.req.addr)
				OFS_CTRL_A: n.hrdata = {24'h000000, state_reg.ctrl_a};
				OFS_CTRL_B: n.hrdata = {24'h000000, state_reg.ctrl_b};
				OFS_RESULT: begin
					n.hrdata = {24'h000000, state_reg.result};
					n.end_flag = 1'b0;
				end
				OFS_STATUS: begin
					n.hrdata = 32'h00000000;
					n.hrdata[END_BIT] = state_reg.end_flag;
					n.hrdata[BUSY_BIT] = state_reg.busy;
				end
				OFS_KEY_WAKE: n.hrdata = {26'h0000000, state_reg.key_s2};
				default: n.hrdata = 32'h00000000;
			endcase
		end

		// successive approximation sequence
		case (state_reg.state)
			ST_IDLE: begin
				n.cnt = 3'h0;
			end
			ST_SAMPLE: begin
				if (state_reg.cnt == SAMPLE_CYCLES - 3'h1) begin
					n.state = ST_CONV;
					n.cnt = 3'h0;
					n.bit_idx = 3'h7;
					n.trial = 8'h80;
				end else begin
					n.cnt = state_reg.cnt + 3'h1;
				end
			end
			ST_CONV: begin
				if (state_reg.cnt == STEP_CYCLES - 3'h1) begin
					kept = state_reg.cmp_s2 ? state_reg.trial : (state_reg.trial & ~bit_mask);
					n.cnt = 3'h0;
					if (state_reg.bit_idx == 3'h0) begin
						n.result = kept;
						n.end_flag = 1'b1;
						n.done_irq = 1'b1;
						n.busy = 1'b0;
						n.state = ST_IDLE;
						n.trial = kept;
					end else begin
						n.bit_idx = state_reg.bit_idx - 3'h1;
						n.trial = kept | 8'(bit_mask >> 1);
					end
				end else begin
					n.cnt = state_reg.cnt + 3'h1;
				end
			end
			default: begin
				n.state = ST_IDLE;
				n.busy = 1'b0;
			end
		endcase

		// register writes in the data phase
		if (state_reg.req.wr_pend) begin
			case (state_reg.req.addr)
				OFS_CTRL_A: begin
					n.ctrl_a = {1'b0, hwdata[6:0]};
					if (new_mode == MODE_OFF) begin
						n.state = ST_IDLE;
						n.busy = 1'b0;
						n.trig_done = 1'b0;
						n.trial = 8'h00;
					end else if (hwdata[START_BIT] && new_mode == MODE_SOFT) begin
						start_req = 1'b1;
					end
				end
				OFS_CTRL_B: n.ctrl_b = hwdata[7:0];
				OFS_KEY_WAKE: n.wake_en = hwdata[7:0] & WAKE_EN_MASK;
				default: begin
				end
			endcase
		end

		// trigger start: one conversion per arming of the mode
		if (state_reg.trig && state_reg.ctrl_a[MODE_HI:MODE_LO] == MODE_TRIG
			&& !state_reg.trig_done && n.ctrl_a[MODE_HI:MODE_LO] == MODE_TRIG) begin
			start_req = 1'b1;
			n.trig_done = 1'b1;
		end

		// starts only from idle; disabled mode never reaches here
		if (start_req && n.state == ST_IDLE) begin
			n.state = ST_SAMPLE;
			n.cnt = 3'h0;
			n.trial = 8'h00;
			n.busy = 1'b1;
			n.end_flag = 1'b0;
		end

		// stop entry wipes the converter and cancels any pending end
		if (stop_entry) begin
			n.ctrl_a = CTRL_A_RST;
			n.ctrl_b = CTRL_B_RST;
			n.result = RESULT_RST;
			n.end_flag = 1'b0;
			n.done_irq = 1'b0;
			n.busy = 1'b0;
			n.state = ST_IDLE;
			n.trig_done = 1'b0;
			n.trial = 8'h00;
			n.cnt = 3'h0;
		end

		state_next = n;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= STATE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign hreadyout = state_reg.hreadyout;
	assign hrdata = state_reg.hrdata;
	assign hresp = 1'b0;
	assign chan_sel = state_reg.ctrl_a[2:0];
	assign sar_trial = state_reg.trial;
	assign sample_hold = state_reg.state[1];
	assign conv_done_irq = state_reg.done_irq;
	assign key_wake_irq = state_reg.wake_irq;
	assign key_conv_trigger = state_reg.trig;

endmodule

//--- tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module tb_top;
	import adc_key_pkg::*;
	logic hclk = 0;
	logic hresetn, hsel, hwrite, stop_entry, cmp_in, hreadyout, hresp, sample_hold, g;
	logic conv_done_irq, key_wake_irq, key_conv_trigger;
	logic [1:0] htrans;
	logic [2:0] hsize, chan_sel;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] sar_trial, q;
	logic [5:0] key_input_n, key_lvl;
	logic [5:0][7:0] vin;
	int err_count = 0;
	int checks = 0;
	initial forever #12.5 hclk = ~hclk;
	adc_key_top i_adc_key_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .stop_entry, .cmp_in, .key_input_n,
		.chan_sel, .sar_trial, .sample_hold, .conv_done_irq, .key_wake_irq, .key_conv_trigger);
	adc_key_partner i_adc_key_partner (.hclk, .sample_hold, .chan_sel, .sar_trial, .vin,
		.key_lvl, .cmp_in, .key_input_n);
	task end_of_test;
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e, input string n);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task hw;
		for (int n = 0; n < 20; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		err_count++;
		end_of_test;
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		hw;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		hw;
		q = hrdata[7:0];
	endtask
	task rc(input logic [11:0] a, input logic [7:0] e, input string n);
		bus(1'b0, a, 8'h00);
		chk(q, e, n);
		chk({7'h00, hresp}, 8'h00, "hresp");
	endtask
	task wsig(input logic t, input logic req);
		g = 1'b0;
		for (int n = 0; n < 1200 && !g; n++) begin
			@(posedge hclk);
			g = t ? key_conv_trigger : conv_done_irq;
		end
		if (req && g !== 1'b1) begin
			err_count++;
			end_of_test;
		end
	endtask
	task conv(input logic [2:0] c, input logic [7:0] v);
		vin[c] <= v;
		bus(1'b1, OFS_CTRL_A, {1'b1, MODE_SOFT, 2'h0, c});
	endtask
	task t_regs;
		rc(OFS_CTRL_A, CTRL_A_RST, "ctrl_a");
		rc(12'h100, 8'h00, "unmapped");
		rc(OFS_KEY_WAKE, 8'h3F, "monitor");
	endtask
	task t_soft;
		conv(3'h2, 8'hA5);
		rc(OFS_STATUS, 8'h10, "busy");
		wsig(1'b0, 1'b1);
		rc(OFS_STATUS, 8'h20, "end");
		conv(3'h4, 8'h3C);
		rc(OFS_RESULT, 8'hA5, "old");
		wsig(1'b0, 1'b1);
		rc(OFS_RESULT, 8'h3C, "code");
		rc(OFS_STATUS, 8'h00, "clear");
	endtask
	task t_abort;
		conv(3'h1, 8'h11);
		repeat (12) @(posedge hclk);
		bus(1'b1, OFS_CTRL_A, 8'h00);
		rc(OFS_STATUS, 8'h00, "abort");
		rc(OFS_RESULT, 8'h3C, "kept");
		bus(1'b1, OFS_CTRL_A, 8'h80);
		wsig(1'b0, 1'b0);
		chk(g, 8'h00, "off start");
	endtask
	task t_stop;
		conv(3'h0, 8'h77);
		repeat (12) @(posedge hclk);
		stop_entry <= 1'b1;
		@(posedge hclk);
		stop_entry <= 1'b0;
		wsig(1'b0, 1'b0);
		chk(g, 8'h00, "stop irq");
		rc(OFS_CTRL_A, 8'h00, "stop ctrl");
		rc(OFS_RESULT, 8'h00, "stop res");
	endtask
	task t_keys;
		bus(1'b1, OFS_KEY_WAKE, 8'h01);
		key_lvl <= 6'h3C;
		repeat (400) @(posedge hclk);
		chk(key_wake_irq, 8'h00, "short");
		key_lvl <= 6'h3D;
		repeat (1000) @(posedge hclk);
		chk(key_wake_irq, 8'h00, "masked");
		rc(OFS_KEY_WAKE, 8'h3D, "levels");
		vin[5] <= 8'hC3;
		bus(1'b1, OFS_KEY_WAKE, 8'h81);
		bus(1'b1, OFS_CTRL_A, {1'b0, MODE_TRIG, 5'h05});
		key_lvl <= 6'h3C;
		wsig(1'b1, 1'b1);
		chk(key_wake_irq, 8'h01, "wake");
		wsig(1'b0, 1'b1);
		rc(OFS_RESULT, 8'hC3, "trig code");
		bus(1'b1, OFS_CTRL_A, 8'h00);
	endtask
	initial begin
		{hsel, htrans, hwrite, haddr, hwdata, stop_entry, hresetn} = '0;
		hsize = 3'h2;
		key_lvl = 6'h3F;
		vin = '0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_soft;
		t_abort;
		t_stop;
		t_keys;
		end_of_test;
	end
endmodule
